// ---- rtl/agm_pkg.sv ----
// package of constants and types for the amplifier gain and mode registers
// assumes: a single 200 MHz clock domain and an active-low async reset
package agm_pkg;

   // ---------------------------------------------------------------
   // serial control word
   // ---------------------------------------------------------------
   localparam logic [6:0] AGM_DEV_ADDR      = 7'h31;
   localparam int         AGM_WORD_BITS     = 16;
   localparam int         AGM_ADDR_BITS     = 7;
   localparam int         AGM_DATA_BITS     = 9;
   localparam logic [3:0] AGM_BYTE_BITS     = 4'h8;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [6:0] AGM_LEFT_GAIN_OFS  = 7'h00;
   localparam logic [6:0] AGM_RIGHT_GAIN_OFS = 7'h01;
   localparam logic [6:0] AGM_MODE_OFS       = 7'h02;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int AGM_GAIN_LINK_BIT   = 7;
   localparam int AGM_SILENCE_BIT     = 6;
   localparam int AGM_GAIN_MSB        = 5;
   localparam int AGM_EDGE_MSB        = 5;
   localparam int AGM_EDGE_LSB        = 4;
   localparam int AGM_OC_RECOVER_BIT  = 3;
   localparam int AGM_OT_RECOVER_BIT  = 2;
   localparam int AGM_RIGHT_MIX_BIT   = 1;
   localparam int AGM_LEFT_MIX_BIT    = 0;

   // ---------------------------------------------------------------
   // reset values and masks
   // ---------------------------------------------------------------
   localparam logic [7:0] AGM_LEFT_GAIN_RST  = 8'h22;
   localparam logic [7:0] AGM_RIGHT_GAIN_RST = 8'h22;
   localparam logic [7:0] AGM_MODE_RST       = 8'h0c;
   localparam logic [7:0] AGM_MODE_WR_MASK   = 8'h3f;
   localparam logic       AGM_PIN_IDLE       = 1'b1;

   // ---------------------------------------------------------------
   // gain decoding: step 0 is 1 dB, each step 0.5 dB, top step 24 dB
   // ---------------------------------------------------------------
   localparam logic [5:0] AGM_GAIN_TOP_STEP  = 6'h2e;
   localparam logic [6:0] AGM_GAIN_BASE_HDB  = 7'h02;

   // ---------------------------------------------------------------
   // serial slave states
   // ---------------------------------------------------------------
   typedef enum logic [6:0] {
      AGM_IDLE     = 7'h01,
      AGM_ADDR     = 7'h02,
      AGM_ADDR_ACK = 7'h04,
      AGM_WR_BYTE  = 7'h08,
      AGM_WR_ACK   = 7'h10,
      AGM_RD_BYTE  = 7'h20,
      AGM_RD_ACK   = 7'h40
   } agm_state_type;

endpackage

// ---- rtl/agm_pin_sync.sv ----
// three-stage synchroniser for the two serial control pins
// assumes: pins are asynchronous to sys_clk and idle high
`timescale 1ns/1ps
module agm_pin_sync
   import agm_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   input  wire logic [1:0] pin_in,
   output logic      [1:0] pin_level
);

   // ---------------------------------------------------------------
   // per-pin stages; level moves only when stages two and three agree
   // ---------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_pin
         logic s1_reg;
         logic s2_reg;
         logic s3_reg;
         logic lvl_reg;
         logic lvl_next;

         always_comb begin
            lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
         end

         always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
               s1_reg  <= AGM_PIN_IDLE;
               s2_reg  <= AGM_PIN_IDLE;
               s3_reg  <= AGM_PIN_IDLE;
               lvl_reg <= AGM_PIN_IDLE;
            end else begin
               s1_reg  <= pin_in[i];
               s2_reg  <= s1_reg;
               s3_reg  <= s2_reg;
               lvl_reg <= lvl_next;
            end
         end

         assign pin_level[i] = lvl_reg;
      end
   endgenerate

endmodule

// ---- rtl/agm_regs.sv ----
// gain and mode control registers with a two-wire serial slave port
// assumes: level_limiter_on comes from logic on sys_clk; scl and sda are
// raw pins and the pad resolves the open-drain sda from sda_oe
//
// Function
// [RL1] Left gain code steps 0.5 dB from 1 dB, resets to 18 dB, saturates at 24 dB.
// [RL2] With level control on, the left gain code sets both channel gains.
// [RL3] Gain-code writes to either channel are ignored while level control is on.
// [RL4] A left write with its link bit set loads the code into both channels.
// [RL5] A right write with its link bit set loads the code into both channels.
// [RL6] Left silence bit set mutes the left input; it resets clear.
// [RL7] Right silence bit set mutes the right input; it resets clear.
// [RL8] Right gain code decodes exactly like the left one.
// [RL9] Edge code 00 is normal edges, any other code slow edges.
// [RL10] Mode bits 3 and 2 enable overcurrent and overtemp recovery, reset set.
// [RL11] Mode bit 1 sends the right input to both outputs, reset clear.
// [RL12] Mode bit 0 sends the left input to both outputs, reset clear.
// [RL13] Each transfer is a 16-bit word, MSB first, 7 address and 9 data bits.
// [RL14] Mode bits 7 and 6 read as zero and ignore writes.
`timescale 1ns/1ps
module agm_regs
   import agm_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic       level_limiter_on,
   output logic      [5:0] left_gain_code,
   output logic      [5:0] right_gain_code,
   output logic      [6:0] left_gain_half_db,
   output logic      [6:0] right_gain_half_db,
   output logic            left_gain_link,
   output logic            right_gain_link,
   output logic            left_silence,
   output logic            right_silence,
   output logic      [1:0] edge_rate_code,
   output logic            edge_rate_slow,
   output logic            overcurrent_autorecover,
   output logic            overtemp_autorecover,
   output logic            right_to_both_mix,
   output logic            left_to_both_mix
);

   // ---------------------------------------------------------------
   // gain decoding
   // ---------------------------------------------------------------
   function automatic logic [5:0] agm_sat_step(input logic [5:0] code);
      agm_sat_step = (code > AGM_GAIN_TOP_STEP) ? AGM_GAIN_TOP_STEP : code;
   endfunction

   function automatic logic [6:0] agm_half_db(input logic [5:0] code);
      agm_half_db = AGM_GAIN_BASE_HDB + {1'b0, agm_sat_step(code)};
   endfunction

   // ---------------------------------------------------------------
   // pin conditioning and bus events
   // ---------------------------------------------------------------
   logic [1:0] pin_level;
   logic       scl_lvl;
   logic       sda_lvl;
   logic       scl_prev_reg;
   logic       sda_prev_reg;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;

   agm_pin_sync u_sync (
      .sys_clk   (sys_clk),
      .nrst      (nrst),
      .pin_in    ({sda_in, scl_in}),
      .pin_level (pin_level)
   );

   assign scl_lvl   = pin_level[0];
   assign sda_lvl   = pin_level[1];
   assign scl_rise  = scl_lvl & ~scl_prev_reg;
   assign scl_fall  = ~scl_lvl & scl_prev_reg;
   assign start_det = scl_lvl & scl_prev_reg & sda_prev_reg & ~sda_lvl;
   assign stop_det  = scl_lvl & scl_prev_reg & ~sda_prev_reg & sda_lvl;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         scl_prev_reg <= AGM_PIN_IDLE;
         sda_prev_reg <= AGM_PIN_IDLE;
      end else begin
         scl_prev_reg <= scl_lvl;
         sda_prev_reg <= sda_lvl;
      end
   end

   // ---------------------------------------------------------------
   // serial slave
   // ---------------------------------------------------------------
   agm_state_type state_reg;
   agm_state_type state_next;
   logic [3:0]    cnt_reg;
   logic [3:0]    cnt_next;
   logic [7:0]    rx_reg;
   logic [7:0]    rx_next;
   logic [7:0]    tx_reg;
   logic [7:0]    tx_next;
   logic [7:0]    hi_reg;
   logic [7:0]    hi_next;
   logic [6:0]    ptr_reg;
   logic [6:0]    ptr_next;
   logic          rw_reg;
   logic          rw_next;
   logic          idx_reg;
   logic          idx_next;
   logic          nack_reg;
   logic          nack_next;
   logic          wr_reg;
   logic          wr_next;
   logic [15:0]   word_reg;
   logic [15:0]   word_next;
   logic          oe_reg;
   logic          oe_next;
   logic [7:0]    rd_data;
   logic [7:0]    left_reg;
   logic [7:0]    right_reg;
   logic [7:0]    mode_reg;

   // read data for the current pointer; unmapped offsets read zero
   always_comb begin
      if (ptr_reg == AGM_LEFT_GAIN_OFS) begin
         rd_data = left_reg;
      end else if (ptr_reg == AGM_RIGHT_GAIN_OFS) begin
         rd_data = right_reg;
      end else if (ptr_reg == AGM_MODE_OFS) begin
         rd_data = mode_reg & AGM_MODE_WR_MASK; // see [RL14]
      end else begin
         rd_data = 8'h00;
      end
   end

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      rx_next    = rx_reg;
      tx_next    = tx_reg;
      hi_next    = hi_reg;
      ptr_next   = ptr_reg;
      rw_next    = rw_reg;
      idx_next   = idx_reg;
      nack_next  = nack_reg;
      word_next  = word_reg;
      wr_next    = 1'b0;
      if (start_det) begin
         state_next = AGM_ADDR;
         cnt_next   = 4'h0;
      end else if (stop_det) begin
         state_next = AGM_IDLE;
      end else begin
         case (state_reg)
            AGM_ADDR: begin
               if (scl_rise) begin
                  rx_next  = {rx_reg[6:0], sda_lvl};
                  cnt_next = cnt_reg + 4'h1;
               end else if (scl_fall && cnt_reg == AGM_BYTE_BITS) begin
                  cnt_next = 4'h0;
                  rw_next  = rx_reg[0];
                  if (rx_reg[7:1] == AGM_DEV_ADDR) begin
                     state_next = AGM_ADDR_ACK;
                  end else begin
                     state_next = AGM_IDLE;
                  end
               end
            end
            AGM_ADDR_ACK: begin
               if (scl_fall) begin
                  idx_next = 1'b0;
                  if (rw_reg) begin
                     state_next = AGM_RD_BYTE;
                     tx_next    = {ptr_reg, 1'b0}; // see [RL13]
                  end else begin
                     state_next = AGM_WR_BYTE;
                  end
               end
            end
            AGM_WR_BYTE: begin
               if (scl_rise) begin
                  rx_next  = {rx_reg[6:0], sda_lvl}; // see [RL13]
                  cnt_next = cnt_reg + 4'h1;
               end else if (scl_fall && cnt_reg == AGM_BYTE_BITS) begin
                  cnt_next   = 4'h0;
                  state_next = AGM_WR_ACK;
                  idx_next   = ~idx_reg;
                  if (!idx_reg) begin
                     hi_next  = rx_reg;
                     ptr_next = rx_reg[7:1];
                  end else begin
                     word_next = {hi_reg, rx_reg}; // see [RL13]
                     wr_next   = 1'b1;
                  end
               end
            end
            AGM_WR_ACK: begin
               if (scl_fall) begin
                  state_next = AGM_WR_BYTE;
               end
            end
            AGM_RD_BYTE: begin
               if (scl_fall) begin
                  tx_next  = {tx_reg[6:0], 1'b0};
                  cnt_next = cnt_reg + 4'h1;
                  if (cnt_reg == AGM_BYTE_BITS - 4'h1) begin
                     cnt_next   = 4'h0;
                     state_next = AGM_RD_ACK;
                  end
               end
            end
            AGM_RD_ACK: begin
               if (scl_rise) begin
                  nack_next = sda_lvl;
               end else if (scl_fall) begin
                  if (nack_reg) begin
                     state_next = AGM_IDLE;
                  end else begin
                     state_next = AGM_RD_BYTE;
                     idx_next   = ~idx_reg;
                     tx_next    = idx_reg ? {ptr_reg, 1'b0} : rd_data;
                  end
               end
            end
            default: begin
               state_next = AGM_IDLE;
            end
         endcase
      end
      oe_next = (state_next == AGM_ADDR_ACK) || (state_next == AGM_WR_ACK)
             || ((state_next == AGM_RD_BYTE) && !tx_next[7]);
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= AGM_IDLE;
         cnt_reg   <= 4'h0;
         rx_reg    <= 8'h00;
         tx_reg    <= 8'h00;
         hi_reg    <= 8'h00;
         ptr_reg   <= 7'h00;
         rw_reg    <= 1'b0;
         idx_reg   <= 1'b0;
         nack_reg  <= 1'b0;
         wr_reg    <= 1'b0;
         word_reg  <= 16'h0000;
         oe_reg    <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         rx_reg    <= rx_next;
         tx_reg    <= tx_next;
         hi_reg    <= hi_next;
         ptr_reg   <= ptr_next;
         rw_reg    <= rw_next;
         idx_reg   <= idx_next;
         nack_reg  <= nack_next;
         wr_reg    <= wr_next;
         word_reg  <= word_next;
         oe_reg    <= oe_next;
      end
   end

   // open drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe  = oe_reg;

   // ---------------------------------------------------------------
   // register bank
   // ---------------------------------------------------------------
   logic [7:0] left_next;
   logic [7:0] right_next;
   logic [7:0] mode_next;
   logic [6:0] wr_addr;
   logic [8:0] wr_data;

   assign wr_addr = word_reg[AGM_WORD_BITS-1 -: AGM_ADDR_BITS];
   assign wr_data = word_reg[AGM_DATA_BITS-1:0];

   always_comb begin
      left_next  = left_reg;
      right_next = right_reg;
      mode_next  = mode_reg;
      if (wr_reg) begin
         if (wr_addr == AGM_LEFT_GAIN_OFS) begin
            left_next[7:6] = wr_data[7:6]; // see [RL6]
            if (!level_limiter_on) begin // see [RL3]
               left_next[5:0] = wr_data[5:0];
               if (wr_data[AGM_GAIN_LINK_BIT]) begin
                  right_next[5:0] = wr_data[5:0]; // see [RL4]
               end
            end
         end else if (wr_addr == AGM_RIGHT_GAIN_OFS) begin
            right_next[7:6] = wr_data[7:6]; // see [RL7]
            if (!level_limiter_on) begin // see [RL3]
               right_next[5:0] = wr_data[5:0];
               if (wr_data[AGM_GAIN_LINK_BIT]) begin
                  left_next[5:0] = wr_data[5:0]; // see [RL5]
               end
            end
         end else if (wr_addr == AGM_MODE_OFS) begin
            mode_next = wr_data[7:0] & AGM_MODE_WR_MASK; // see [RL14]
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         left_reg  <= AGM_LEFT_GAIN_RST;  // see [RL1]
         right_reg <= AGM_RIGHT_GAIN_RST; // see [RL8]
         mode_reg  <= AGM_MODE_RST;       // see [RL10]
      end else begin
         left_reg  <= left_next;
         right_reg <= right_next;
         mode_reg  <= mode_next;
      end
   end

   // ---------------------------------------------------------------
   // control outputs, registered
   // ---------------------------------------------------------------
   logic [5:0] lcode_reg;
   logic [5:0] lcode_next;
   logic [5:0] rcode_reg;
   logic [5:0] rcode_next;
   logic [6:0] lhdb_reg;
   logic [6:0] lhdb_next;
   logic [6:0] rhdb_reg;
   logic [6:0] rhdb_next;
   logic [5:0] rsrc;

   always_comb begin
      // see [RL2]
      rsrc       = level_limiter_on ? left_reg[5:0] : right_reg[5:0];
      lcode_next = agm_sat_step(left_reg[5:0]); // see [RL1]
      rcode_next = agm_sat_step(rsrc);          // see [RL8]
      lhdb_next  = agm_half_db(left_reg[5:0]);  // see [RL1]
      rhdb_next  = agm_half_db(rsrc);           // see [RL2]
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         lcode_reg <= AGM_LEFT_GAIN_RST[5:0];
         rcode_reg <= AGM_RIGHT_GAIN_RST[5:0];
         lhdb_reg  <= AGM_GAIN_BASE_HDB + {1'b0, AGM_LEFT_GAIN_RST[5:0]};
         rhdb_reg  <= AGM_GAIN_BASE_HDB + {1'b0, AGM_RIGHT_GAIN_RST[5:0]};
      end else begin
         lcode_reg <= lcode_next;
         rcode_reg <= rcode_next;
         lhdb_reg  <= lhdb_next;
         rhdb_reg  <= rhdb_next;
      end
   end

   assign left_gain_code          = lcode_reg;
   assign right_gain_code         = rcode_reg;
   assign left_gain_half_db       = lhdb_reg;
   assign right_gain_half_db      = rhdb_reg;
   assign left_gain_link          = left_reg[AGM_GAIN_LINK_BIT];
   assign right_gain_link         = right_reg[AGM_GAIN_LINK_BIT];
   assign left_silence            = left_reg[AGM_SILENCE_BIT];  // see [RL6]
   assign right_silence           = right_reg[AGM_SILENCE_BIT]; // see [RL7]
   assign edge_rate_code          = mode_reg[AGM_EDGE_MSB:AGM_EDGE_LSB];
   // see [RL9]
   assign edge_rate_slow          = |mode_reg[AGM_EDGE_MSB:AGM_EDGE_LSB];
   assign overcurrent_autorecover = mode_reg[AGM_OC_RECOVER_BIT]; // see [RL10]
   assign overtemp_autorecover    = mode_reg[AGM_OT_RECOVER_BIT]; // see [RL10]
   assign right_to_both_mix       = mode_reg[AGM_RIGHT_MIX_BIT];  // see [RL11]
   assign left_to_both_mix        = mode_reg[AGM_LEFT_MIX_BIT];   // see [RL12]

endmodule

// ---- sim/agm_regs_properties.sv ----
// checker for the gain and mode register block, sees only its ports
// assumes: one clock domain, active-low asynchronous reset
`timescale 1ns/1ps
module agm_regs_properties
   import agm_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       nrst,
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe,
   input wire logic       level_limiter_on,
   input wire logic [5:0] left_gain_code,
   input wire logic [5:0] right_gain_code,
   input wire logic [6:0] left_gain_half_db,
   input wire logic [6:0] right_gain_half_db,
   input wire logic       left_gain_link,
   input wire logic       right_gain_link,
   input wire logic       left_silence,
   input wire logic       right_silence,
   input wire logic [1:0] edge_rate_code,
   input wire logic       edge_rate_slow,
   input wire logic       overcurrent_autorecover,
   input wire logic       overtemp_autorecover,
   input wire logic       right_to_both_mix,
   input wire logic       left_to_both_mix
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   // ---------------------------------------------------------------
   // sequences
   // ---------------------------------------------------------------
   sequence s_left_settled;  $stable(left_gain_code)[*2];  endsequence
   sequence s_right_settled; $stable(right_gain_code)[*2]; endsequence
   sequence s_limiter_held;  level_limiter_on[*4];         endsequence
   sequence s_limiter_off;   !level_limiter_on[*3];        endsequence

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   AST_SDA_OPEN_DRAIN: assert property (sda_out == 1'b0)
      else $error("sda driven high");
   AST_OE_ON_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("sda changed while scl high");
   AST_LEFT_SAT: assert property (left_gain_code <= 6'h2e)
      else $error("left gain step above top");
   AST_RIGHT_SAT: assert property (right_gain_code <= 6'h2e)
      else $error("right gain step above top");
   AST_LEFT_HDB: assert property (s_left_settled |->
      left_gain_half_db == {1'b0, left_gain_code} + 7'h02)
      else $error("left half db decode wrong");
   AST_RIGHT_HDB: assert property (s_right_settled |->
      right_gain_half_db == {1'b0, right_gain_code} + 7'h02)
      else $error("right half db decode wrong");
   AST_LIMIT_COPY: assert property (s_limiter_held |->
      right_gain_code == left_gain_code)
      else $error("right gain not from left under limiter");
   AST_LIMIT_FREEZE: assert property (s_limiter_held |->
      $stable(left_gain_code))
      else $error("gain code changed under limiter");
   AST_SLOW_EDGE: assert property (edge_rate_slow ==
      (edge_rate_code != 2'b00))
      else $error("slow edge flag wrong");
   AST_MODE_IN_ACK: assert property ($changed({edge_rate_code,
      overcurrent_autorecover, overtemp_autorecover, right_to_both_mix,
      left_to_both_mix}) |-> ##[0:3] sda_oe)
      else $error("mode changed outside a write");
   AST_SILENCE_IN_ACK: assert property ($changed({left_silence,
      right_silence}) |-> ##[0:3] sda_oe)
      else $error("silence changed outside a write");
   AST_LEFT_LINK: assert property (left_gain_link &&
      $changed(left_gain_code) |-> ##[0:1] right_gain_code == left_gain_code)
      else $error("linked left write missed right");
   AST_RIGHT_LINK: assert property (s_limiter_off ##0 (right_gain_link &&
      $changed(right_gain_code)) |-> ##[0:1] left_gain_code == right_gain_code)
      else $error("linked right write missed left");
endmodule

// ---- sim/agm_host_model.sv ----
// two-wire host that writes and reads the control registers
// assumes: sda_line is the resolved wire with a pull-up
`timescale 1ns/1ps
module agm_host_model (
   input  wire logic sys_clk,
   input  wire logic sda_line,
   output logic      scl_pin,
   output logic      sda_low
);
   localparam int PHASE = 8;

   initial begin
      scl_pin = 1'b1;
      sda_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // also serves as repeated start
   task automatic start_cond();
      sda_low <= 1'b0;
      tick(PHASE);
      scl_pin <= 1'b1;
      tick(PHASE);
      sda_low <= 1'b1;
      tick(PHASE);
      scl_pin <= 1'b0;
      tick(2);
   endtask

   task automatic stop_cond();
      sda_low <= 1'b1;
      tick(PHASE);
      scl_pin <= 1'b1;
      tick(PHASE);
      sda_low <= 1'b0;
      tick(PHASE);
   endtask

   // data changes only while scl is low, wire sampled at end of high
   task automatic clock_bit(input logic b, output logic s);
      sda_low <= !b;
      tick(PHASE);
      scl_pin <= 1'b1;
      tick(PHASE);
      s = sda_line;
      scl_pin <= 1'b0;
      tick(2);
   endtask

   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(b[i], s);
      end
      clock_bit(1'b1, s);
      ack = !s;
   endtask

   task automatic recv_byte(input logic more, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(1'b1, s);
         b[i] = s;
      end
      clock_bit(!more, s);
   endtask
endmodule

// ---- sim/tb.sv ----
// self-checking bench for the gain and mode register block
// assumes: host model in sim/, design package and modules in rtl/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; $display("FAIL %s expected %h seen %h", nm, e, g); end end
module tb
   import agm_pkg::*;
;
   logic       sys_clk, nrst, scl_pin, sda_low, sda_line, level_limiter_on;
   logic       sda_out, sda_oe, left_gain_link, right_gain_link;
   logic       left_silence, right_silence, edge_rate_slow;
   logic       overcurrent_autorecover, overtemp_autorecover;
   logic       right_to_both_mix, left_to_both_mix, ack;
   logic [5:0] left_gain_code, right_gain_code, prev;
   logic [6:0] left_gain_half_db, right_gain_half_db;
   logic [1:0] edge_rate_code;
   logic [7:0] rv, m;
   logic [7:0] codes[4] = '{8'h00, 8'h2d, 8'h2e, 8'h3f};
   logic [5:0] sat[4]   = '{6'h00, 6'h2d, 6'h2e, 6'h2e};
   int         err_total, check_count;

   assign sda_line = (sda_oe ? sda_out : 1'b1) & ~sda_low;

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   agm_host_model i_host (.sys_clk(sys_clk), .sda_line(sda_line),
      .scl_pin(scl_pin), .sda_low(sda_low));
   agm_regs i_dut (.*, .scl_in(scl_pin), .sda_in(sda_line));

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic write_reg(input logic [6:0] ofs, input logic [7:0] d);
      logic a;
      i_host.start_cond();
      i_host.send_byte({AGM_DEV_ADDR, 1'b0}, a);
      `CHK("address ack", 1'b1, a)
      i_host.send_byte({ofs, 1'b0}, a);
      i_host.send_byte(d, a);
      `CHK("data ack", 1'b1, a)
      i_host.stop_cond();
   endtask

   task automatic read_reg(input logic [6:0] ofs, output logic [7:0] v);
      logic       a;
      logic [7:0] p;
      i_host.start_cond();
      i_host.send_byte({AGM_DEV_ADDR, 1'b0}, a);
      i_host.send_byte({ofs, 1'b0}, a);
      i_host.start_cond();
      i_host.send_byte({AGM_DEV_ADDR, 1'b1}, a);
      `CHK("read ack", 1'b1, a)
      i_host.recv_byte(1'b1, p);
      `CHK("read pointer", {ofs, 1'b0}, p)
      i_host.recv_byte(1'b0, v);
      i_host.stop_cond();
   endtask

   task automatic chk_gain(input logic [5:0] l, input logic [5:0] r);
      `CHK("left code", l, left_gain_code)
      `CHK("right code", r, right_gain_code)
      `CHK("left half db", {1'b0, l} + 7'h02, left_gain_half_db)
      `CHK("right half db", {1'b0, r} + 7'h02, right_gain_half_db)
   endtask

   task automatic chk_mode(input logic [5:0] v);
      `CHK("edge code", v[5:4], edge_rate_code)
      `CHK("edge slow", |v[5:4], edge_rate_slow)
      `CHK("oc recover", v[3], overcurrent_autorecover)
      `CHK("ot recover", v[2], overtemp_autorecover)
      `CHK("right mix", v[1], right_to_both_mix)
      `CHK("left mix", v[0], left_to_both_mix)
   endtask

   initial begin
      nrst = 1'b0;
      level_limiter_on = 1'b0;
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (8) @(posedge sys_clk);
      chk_gain(6'h22, 6'h22);
      chk_mode(6'h0c);
      `CHK("left silence", 1'b0, left_silence)
      `CHK("right silence", 1'b0, right_silence)
      `CHK("left link", 1'b0, left_gain_link)
      `CHK("right link", 1'b0, right_gain_link)
      read_reg(AGM_MODE_OFS, rv);
      `CHK("mode read", 8'h0c, rv)
      // supply taken as above 4.0 V, so every edge code may be used
      for (int i = 0; i < 4; i++) begin
         m = {2'b11, i[1:0], ~i[1:0], i[1:0]};
         write_reg(AGM_MODE_OFS, m);
         chk_mode(m[5:0]);
         read_reg(AGM_MODE_OFS, rv);
         `CHK("mode top bits", {2'b00, m[5:0]}, rv)
      end
      prev = 6'h22;
      for (int i = 0; i < 4; i++) begin
         write_reg(AGM_LEFT_GAIN_OFS, codes[i]);
         chk_gain(sat[i], prev);
         write_reg(AGM_RIGHT_GAIN_OFS, codes[i]);
         chk_gain(sat[i], sat[i]);
         prev = sat[i];
      end
      write_reg(AGM_RIGHT_GAIN_OFS, 8'h03);
      chk_gain(6'h2e, 6'h03);
      write_reg(AGM_LEFT_GAIN_OFS, 8'hc5);
      chk_gain(6'h05, 6'h05);
      `CHK("left link", 1'b1, left_gain_link)
      `CHK("left silence", 1'b1, left_silence)
      write_reg(AGM_RIGHT_GAIN_OFS, 8'hc9);
      chk_gain(6'h09, 6'h09);
      `CHK("right link", 1'b1, right_gain_link)
      `CHK("right silence", 1'b1, right_silence)
      write_reg(AGM_RIGHT_GAIN_OFS, 8'h01);
      chk_gain(6'h09, 6'h01);
      level_limiter_on <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk_gain(6'h09, 6'h09);
      write_reg(AGM_LEFT_GAIN_OFS, 8'h10);
      chk_gain(6'h09, 6'h09);
      `CHK("left silence", 1'b0, left_silence)
      write_reg(AGM_RIGHT_GAIN_OFS, 8'h50);
      chk_gain(6'h09, 6'h09);
      `CHK("right silence", 1'b1, right_silence)
      level_limiter_on <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk_gain(6'h09, 6'h01);
      read_reg(AGM_LEFT_GAIN_OFS, rv);
      `CHK("left read", 8'h09, rv)
      write_reg(7'h05, 8'hff);
      read_reg(7'h05, rv);
      `CHK("unmapped read", 8'h00, rv)
      chk_gain(6'h09, 6'h01);
      i_host.start_cond();
      i_host.send_byte({7'h30, 1'b0}, ack);
      i_host.stop_cond();
      `CHK("foreign address ack", 1'b0, ack)
      give_verdict();
   end

   initial begin
      repeat (80000) @(posedge sys_clk);
      err_total++;
      give_verdict();
   end
endmodule

bind agm_regs agm_regs_properties i_props (.*);
